/* File: core/sgr_fifo.sv */
// Bit FIFO between the edge decoder and the shifter
`timescale 1ns/1ns
`default_nettype none
module sgr_fifo #(
  parameter int unsigned W = 1,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  sgr_stream_if.snk wr,
  sgr_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr, next_wptr;
  logic [AW:0] rptr, next_rptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wptr == rptr);
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rptr[AW-1:0]];
  assign push = wr.valid && !full;
  assign pop = rd.ready && !empty;

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    if (push) begin
      next_wptr = wptr + 1'b1;
    end
    if (pop) begin
      next_rptr = rptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage needs no reset; pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end
endmodule // sgr_fifo
`default_nettype wire

/* File: core/sgr_pwm.sv */
// Grayscale latch and three-channel modulator
`timescale 1ns/1ns
`default_nettype none
module sgr_pwm
  import sgr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [DATA_W-1:0] data,
  output logic [NUM_CHAN-1:0] led
);
  logic [DATA_W-1:0] level, next_level;
  logic [CHAN_W-1:0] count, next_count;
  logic [NUM_CHAN-1:0] next_led;
  logic [NUM_CHAN-1:0] on_cond;

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_ch
    assign on_cond[i] = (count != '0) &&
      (count <= level[sgr_chan_lsb(i) +: CHAN_W]);
  end

  always_comb begin
    next_level = level;
    next_count = count;
    next_led = on_cond;
    if (load) begin
      next_level = data;
      next_count = '0;
      next_led = '0;
    end else if (tick) begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
      count <= '0;
      led <= '0;
    end else begin
      level <= next_level;
      count <= next_count;
      led <= next_led;
    end
  end
endmodule // sgr_pwm
`default_nettype wire

/* File: core/sgr_top.sv */
// Single-wire grayscale receiver top
`timescale 1ns/1ns
`default_nettype none
module sgr_top
  import sgr_pkg::*;
#(
  parameter int unsigned PERIOD_MAX_CYC = PERIOD_MAX_DEF,
  parameter int unsigned PWM_DIV = PWM_DIV_DEF,
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_line_in,
  output logic serial_line_out,
  output logic [NUM_CHAN-1:0] led_sink_output
);
  localparam logic [TIMER_W-1:0] MIN_P = TIMER_W'(PERIOD_MIN_CYC);
  localparam logic [TIMER_W-1:0] MAX_P = TIMER_W'(PERIOD_MAX_CYC);
  localparam int unsigned DIV_W = $clog2(PWM_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PWM_DIV - 1);

  function automatic logic [TIMER_W-1:0] sat_inc(
    input logic [TIMER_W-1:0] v
  );
    return (&v) ? v : v + 1'b1;
  endfunction

  sgr_stream_if #(.W(1)) bit_in ();
  sgr_stream_if #(.W(1)) bit_out ();

  sgr_state_t state, next_state;
  logic line_q, next_line_q;
  logic [TIMER_W-1:0] edge_timer, next_edge_timer;
  logic [TIMER_W-1:0] low_timer, next_low_timer;
  logic [TIMER_W-1:0] period, next_period;
  logic [TIMER_W-1:0] eos_lim;
  logic [TIMER_W-1:0] latch_lim;
  logic [1:0] zero_pend, next_zero_pend;
  logic bit_pend, next_bit_pend;
  logic bit_val, next_bit_val;
  logic next_out;
  logic rise;
  logic push_fire;
  logic latch_req;
  logic [PKT_W-1:0] shreg, next_shreg;
  logic latch_pend, next_latch_pend;
  logic load, next_load;
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic tick, next_tick;

  assign rise = serial_line_in && !line_q;
  assign eos_lim = period << EOS_SHIFT;
  assign latch_lim = period << LATCH_SHIFT;

  // Zeros from measurement go ahead of any data bit
  assign bit_in.valid = (zero_pend != 2'h0) || bit_pend;
  assign bit_in.data = (zero_pend != 2'h0) ? 1'b0 : bit_val;
  assign push_fire = bit_in.valid && bit_in.ready;
  assign latch_req = (state == SGR_FORWARD) && (low_timer == latch_lim);

  always_comb begin
    next_line_q = serial_line_in;
    next_edge_timer = rise ? '0 : sat_inc(edge_timer);
    next_low_timer = serial_line_in ? '0 : sat_inc(low_timer);
    next_state = state;
    next_period = period;
    next_zero_pend = zero_pend;
    next_bit_pend = bit_pend;
    next_bit_val = bit_val;
    if (push_fire) begin
      if (zero_pend != 2'h0) begin
        next_zero_pend = zero_pend - 2'h1;
      end else begin
        next_bit_pend = 1'b0;
      end
    end
    case (state)
      SGR_IDLE: begin
        // Hold off until the pending latch has been served
        if (rise && !latch_pend) begin
          next_state = SGR_MEASURE;
        end
      end
      SGR_MEASURE: begin
        if (rise) begin
          if (edge_timer >= MIN_P && edge_timer <= MAX_P) begin
            next_period = edge_timer;
            next_zero_pend = MEAS_ZEROS;
            next_state = SGR_DECODE;
          end
        end else if (edge_timer > MAX_P) begin
          next_state = SGR_IDLE;
        end
      end
      SGR_DECODE: begin
        if (rise) begin
          next_bit_pend = 1'b1;
          next_bit_val = (edge_timer < (period >> 1));
        end else if (low_timer == eos_lim) begin
          next_state = SGR_FORWARD;
        end
      end
      SGR_FORWARD: begin
        if (latch_req) begin
          next_state = SGR_IDLE;
        end
      end
      default: begin
        next_state = SGR_IDLE;
      end
    endcase
    next_out = (next_state == SGR_FORWARD) && serial_line_in;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= SGR_IDLE;
      line_q <= 1'b0;
      edge_timer <= '0;
      low_timer <= '0;
      period <= '0;
      zero_pend <= 2'h0;
      bit_pend <= 1'b0;
      bit_val <= 1'b0;
      serial_line_out <= 1'b0;
    end else begin
      state <= next_state;
      line_q <= next_line_q;
      edge_timer <= next_edge_timer;
      low_timer <= next_low_timer;
      period <= next_period;
      zero_pend <= next_zero_pend;
      bit_pend <= next_bit_pend;
      bit_val <= next_bit_val;
      serial_line_out <= next_out;
    end
  end

  // Drain one bit per modulator tick; the FIFO soaks up the gap
  assign bit_out.ready = tick;

  always_comb begin
    next_shreg = shreg;
    next_latch_pend = latch_pend;
    next_load = 1'b0;
    if (bit_out.valid && bit_out.ready) begin
      next_shreg = {shreg[PKT_W-2:0], bit_out.data};
    end
    if (latch_req) begin
      next_latch_pend = 1'b1;
    end else if (latch_pend && !bit_out.valid) begin
      next_latch_pend = 1'b0;
      next_load = (shreg[PKT_W-1:CMD_LSB] == WRITE_CMD);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shreg <= '0;
      latch_pend <= 1'b0;
      load <= 1'b0;
    end else begin
      shreg <= next_shreg;
      latch_pend <= next_latch_pend;
      load <= next_load;
    end
  end

  // Tick divider stands in for the internal oscillator
  always_comb begin
    next_tick = (div_cnt == DIV_LAST);
    next_div_cnt = next_tick ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  sgr_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .wr(bit_in),
    .rd(bit_out)
  );

  sgr_pwm u_pwm (
    .clk(ref_clk),
    .rst(rst),
    .tick(tick),
    .load(load),
    .data(shreg[DATA_W-1:0]),
    .led(led_sink_output)
  );
endmodule // sgr_top
`default_nettype wire

/* File: shared/sgr_pkg.sv */
// Constants and types of the single-wire grayscale receiver
`default_nettype none
package sgr_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PERIOD_MIN_NS = 1660;
  localparam int unsigned PERIOD_MAX_NS = 50000;
  // Least time rounds up, longest time rounds down
  localparam int unsigned PERIOD_MIN_CYC =
    (PERIOD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PERIOD_MAX_DEF = PERIOD_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned TIMER_W = 20;
  localparam int unsigned EOS_SHIFT = 2;
  localparam int unsigned LATCH_SHIFT = 3;
  localparam int unsigned PKT_W = 32;
  localparam int unsigned CHAN_W = 8;
  localparam int unsigned NUM_CHAN = 3;
  localparam int unsigned DATA_W = CHAN_W * NUM_CHAN;
  localparam int unsigned CMD_LSB = 24;
  localparam logic [CHAN_W-1:0] WRITE_CMD = 8'h3a;
  localparam logic [1:0] MEAS_ZEROS = 2'h2;
  localparam int unsigned PWM_DIV_DEF = 21;
  localparam int unsigned FIFO_DEPTH_DEF = 16;

  typedef enum logic [1:0] {
    SGR_IDLE = 2'b00,
    SGR_MEASURE = 2'b01,
    SGR_DECODE = 2'b10,
    SGR_FORWARD = 2'b11
  } sgr_state_t;

  // Channel i (first, second, third) sits at bits 16, 8, 0
  function automatic int unsigned sgr_chan_lsb(input int unsigned i);
    return (NUM_CHAN - 1 - i) * CHAN_W;
  endfunction
endpackage
`default_nettype wire

/* File: shared/sgr_stream_if.sv */
// Valid/ready carrier between receiver modules
`timescale 1ns/1ns
`default_nettype none
interface sgr_stream_if #(parameter int unsigned W = 1) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sgr_stream_if
`default_nettype wire

/* File: verification/sgr_host.sv */
// Host model driving the single data wire
`timescale 1ns/1ns
`default_nettype none
module sgr_host #(
  parameter int N = 250
) (
  input wire logic clk,
  output logic line
);
  initial line = 1'b0;
  // Spacing g between rising edges, short high so any gap above 8 fits
  task automatic rise(input int g);
    repeat (g - 8) @(posedge clk);
    line <= 1'b1;
    repeat (8) @(posedge clk);
    line <= 1'b0;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic packet(input logic [31:0] w);
    rise(9);
    rise(N);
    for (int i = 29; i >= 0; i--) begin
      rise(w[i] ? N / 2 - 1 : N);
    end
  endtask
endmodule // sgr_host
`default_nettype wire

/* File: verification/sgr_top_assertions.sv */
// Checker for the single-wire grayscale receiver
`timescale 1ns/1ns
`default_nettype none
module sgr_checker
  import sgr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_line_in,
  input wire logic serial_line_out,
  input wire logic [NUM_CHAN-1:0] led_sink_output
);
  // Thresholds sit below 4P and 8P of the shortest legal period
  logic [10:0] low_cnt, next_low_cnt;
  logic eos_seen, next_eos_seen, lat_seen, next_lat_seen;
  always_comb begin
    next_low_cnt = serial_line_in ? 11'h0 : low_cnt + {10'h0, ~&low_cnt};
    next_eos_seen = eos_seen | (low_cnt >= 11'h320);
    next_lat_seen = lat_seen | (low_cnt >= 11'h640);
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_cnt <= 11'h0;
      eos_seen <= 1'b0;
      lat_seen <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      eos_seen <= next_eos_seen;
      lat_seen <= next_lat_seen;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (
    $fell(rst) |-> !serial_line_out && led_sink_output == 3'h0)
    else $error("outputs not quiet after reset");
  a_fwd_source: assert property (
    serial_line_out |-> $past(serial_line_in))
    else $error("output high without input high");
  a_fwd_fall: assert property (
    $fell(serial_line_out) |-> !$past(serial_line_in))
    else $error("output fell while input high");
  a_fwd_after_eos: assert property (
    $rose(serial_line_out) |-> eos_seen)
    else $error("forwarding before end of packet");
  a_led_dark: assert property (
    !lat_seen |-> led_sink_output == 3'h0)
    else $error("output on before any latch");
  a_on_holds: assert property (
    $rose(led_sink_output[0]) && low_cnt < 11'h640
      |=> led_sink_output[0] [*8])
    else $error("first channel on shorter than a tick");
  a_off_holds: assert property (
    $fell(led_sink_output[0]) && low_cnt < 11'h640
      |=> !led_sink_output[0] [*8])
    else $error("first channel off shorter than a tick");
  a_third_gap: assert property (
    $fell(led_sink_output[2]) && low_cnt < 11'h640
      |=> !led_sink_output[2] [*8])
    else $error("third channel off shorter than a tick");
endmodule // sgr_checker
bind sgr_top sgr_checker u_sgr_checker (
  .ref_clk(ref_clk),
  .rst(rst),
  .serial_line_in(serial_line_in),
  .serial_line_out(serial_line_out),
  .led_sink_output(led_sink_output)
);
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the single-wire grayscale receiver
`timescale 1ns/1ns
`default_nettype none
module testbench
  import sgr_pkg::*;
;
  localparam int N = 250;
  localparam int DIV = PWM_DIV_DEF;
  logic ref_clk, rst, serial_line_in, serial_line_out;
  logic [NUM_CHAN-1:0] led_sink_output;
  logic out_q = 1'b0;
  int failures, compares;
  int fwd_rises = 0;
  sgr_top #(.PWM_DIV(DIV)) u_sgr_top (
    .ref_clk(ref_clk),
    .rst(rst),
    .serial_line_in(serial_line_in),
    .serial_line_out(serial_line_out),
    .led_sink_output(led_sink_output)
  );
  sgr_host #(.N(N)) u_sgr_host (.clk(ref_clk), .line(serial_line_in));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    out_q <= serial_line_out;
    if (serial_line_out && !out_q) begin
      fwd_rises <= fwd_rises + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Window of one full frame, so the phase of the load does not matter
  task automatic pwm_check(input logic [23:0] lv);
    logic [31:0] on [NUM_CHAN];
    for (int i = 0; i < NUM_CHAN; i++) begin
      on[i] = 32'h0;
    end
    repeat (256 * DIV) begin
      @(negedge ref_clk);
      for (int i = 0; i < NUM_CHAN; i++) begin
        on[i] += {31'h0, led_sink_output[i]};
      end
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      check(on[i], 32'(lv[23 - 8 * i -: 8]) * DIV);
    end
  endtask
  task automatic t_cascade();
    int base;
    @(negedge ref_clk);
    check({28'h0, serial_line_out, led_sink_output}, 32'h0);
    u_sgr_host.packet(32'h3a0180ff);
    u_sgr_host.idle(5 * N);
    // Only the monitor writes the count; take a snapshot instead
    base = fwd_rises;
    u_sgr_host.packet(32'h3a112233);
    u_sgr_host.idle(20);
    @(negedge ref_clk);
    check(32'(fwd_rises - base), 32'h20);
    check({29'h0, led_sink_output}, 32'h0);
    u_sgr_host.idle(14 * N);
    pwm_check(24'h0180ff);
  endtask
  task automatic t_bad_cmd();
    u_sgr_host.packet(32'h3b102030);
    u_sgr_host.idle(14 * N);
    pwm_check(24'h0180ff);
  endtask
  task automatic t_levels();
    u_sgr_host.packet(32'h3a0002fe);
    u_sgr_host.idle(14 * N);
    pwm_check(24'h0002fe);
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_cascade();
    t_bad_cmd();
    t_levels();
    results();
  end
endmodule // testbench
`default_nettype wire
